// ### verilog/acr_defines.vh
// Constants for the channel calibration and configuration register slice
`ifndef ACR_DEFINES_VH
`define ACR_DEFINES_VH

// ----------------------------------------------------------------------
// Register indices (byte address is four times the index)
// ----------------------------------------------------------------------
`define ACR_IDX_OFS_HI     8'h14
`define ACR_IDX_OFS_LO     8'h15
`define ACR_IDX_GAIN_HI    8'h16
`define ACR_IDX_GAIN_LO    8'h17
`define ACR_IDX_CH3_CHANNEL_CONFIG    8'h18
`define ACR_IDX_BASE       8'h14
`define ACR_NUM_REGS       5
`define ACR_SEL_W          3
`define ACR_SEL_OFS_HI     3'h0
`define ACR_SEL_OFS_LO     3'h1
`define ACR_SEL_GAIN_HI    3'h2
`define ACR_SEL_GAIN_LO    3'h3
`define ACR_SEL_CH3_CHANNEL_CONFIG    3'h4
`define ACR_SEL_LAST       3'h4

// ----------------------------------------------------------------------
// Bus widths and alignment
// ----------------------------------------------------------------------
`define ACR_ADDR_W         10
`define ACR_REG_W          16
`define ACR_ALIGN_OK       2'b00
`define ACR_BUS_ZERO       32'h0000_0000
`define ACR_UPPER_ZERO     16'h0000

// ----------------------------------------------------------------------
// Reset values, packed by select index (index 0 in the low word)
// ----------------------------------------------------------------------
`define ACR_RST_OFS_HI     16'h0000
`define ACR_RST_OFS_LO     16'h0000
`define ACR_RST_GAIN_HI    16'h8000
`define ACR_RST_GAIN_LO    16'h0000
`define ACR_RST_CH3_CHANNEL_CONFIG    16'h0000
`define ACR_RESET_VEC      {`ACR_RST_CH3_CHANNEL_CONFIG, `ACR_RST_GAIN_LO, `ACR_RST_GAIN_HI, \
                            `ACR_RST_OFS_LO, `ACR_RST_OFS_HI}

// ----------------------------------------------------------------------
// Writable bits; every other bit is read-only zero
// ----------------------------------------------------------------------
`define ACR_WM_FULL        16'hFFFF
`define ACR_WM_LOW_PAIR    16'hFF00
`define ACR_WM_CH3_CHANNEL_CONFIG     16'hFFC7
`define ACR_WMASK_VEC      {`ACR_WM_CH3_CHANNEL_CONFIG, `ACR_WM_LOW_PAIR, `ACR_WM_FULL, \
                            `ACR_WM_LOW_PAIR, `ACR_WM_FULL}

// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define ACR_LOWER_BYTE     15:8
`define ACR_PHASE_FLD      15:6
`define ACR_PHASE_SIGN     15
`define ACR_DCOFF_BIT      2
`define ACR_MUX_FLD        1:0

// ----------------------------------------------------------------------
// Input selections and filter codes
// ----------------------------------------------------------------------
`define ACR_MUX_PINS       2'b00
`define ACR_MUX_SHORT      2'b01
`define ACR_MUX_POS_TEST   2'b10
`define ACR_MUX_NEG_TEST   2'b11
`define ACR_DC_BYPASS      4'h0
`define ACR_GAIN_UNITY     24'h80_0000
`define ACR_CORR_ZERO      24'h00_0000
`define ACR_PHASE_ZERO     10'h000
`define ACR_PHASE_ONE      10'h001

`endif

// ### verilog/acr_field_reg.v
// One 16-bit register with a per-bit write mask and byte lanes
`timescale 1ns/1ps
`include "acr_defines.vh"

module acr_field_reg #(
  parameter [15:0] RESET_VAL = 16'h0000,
  parameter [15:0] WR_MASK   = 16'hFFFF
) (
  input  wire        clk,
  input  wire        reset_n,
  input  wire        wrEn,
  input  wire [15:0] wrData,
  input  wire [1:0]  byteEn,
  output reg  [15:0] value_q
);

  // ----------------------------------------------------------------------
  // Write mask
  // ----------------------------------------------------------------------
  // Only bits that are writable and in an enabled lane may change
  wire [15:0] laneMask;
  wire [15:0] bitMask;

  assign laneMask = {{8{byteEn[1]}}, {8{byteEn[0]}}};
  assign bitMask  = laneMask & WR_MASK;

  // ----------------------------------------------------------------------
  // Storage
  // ----------------------------------------------------------------------
  // Read-only bits hold their reset value, which is zero for all of them
  always @(posedge clk) begin
    if (!reset_n) begin
      value_q <= RESET_VAL;
    end else if (wrEn) begin
      value_q <= (value_q & ~bitMask) | (wrData & bitMask);
    end
  end

endmodule

// ### verilog/acr_cal_regs.v
// APB register slice: channel 2 offset and gain words, channel 3 configuration
//
// Overview of operation
// - Offset high register holds offset bits 23..8, signed two's complement
// - Offset low register bits 15..8 hold offset bits 7..0
// - Low byte of offset-low and gain-low is read-only, reads zero
// - Gain high register holds gain bits 23..8 in all sixteen bits
// - Gain low register bits 15..8 hold gain bits 7..0
// - The 24-bit gain is an unsigned fraction from zero to below two
// - Reset gives gain high 8000h, all other calibration registers zero
// - Channel 3 phase delay is signed ten bits at 15..6, reset zero
// - Channel 3 configuration bits 5..3 are reserved and read zero
// - Bit 2 turns channel 3 DC-blocking filter off; reset zero
// - Bits 1..0 pick pins, shorted inputs, positive or negative test
// - Disable clear follows shared DC-block field; set bypasses this channel
`timescale 1ns/1ps
`include "acr_defines.vh"

module acr_cal_regs (
  input  wire        clk,
  input  wire        reset_n,
  // APB slave
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [9:0]  paddr,
  input  wire [31:0] pwdata,
  input  wire [3:0]  pstrb,
  output reg  [31:0] prdata,
  output reg         pready,
  output reg         pslverr,
  // Shared DC-block setting from the global control logic
  input  wire [3:0]  globalDcFilterSetting,
  // Channel 2 calibration words
  output reg  [23:0] ch2OffsetCorr_q,
  output reg  [23:0] ch2GainCorr_q,
  output reg         ch2GainUnity_q,
  // Channel 3 configuration
  output reg  [9:0]  ch3PhaseDelay_q,
  output reg         ch3PhaseNegative_q,
  output reg  [9:0]  ch3PhaseMagnitude_q,
  output reg         ch3DcFilterOff_q,
  output reg  [3:0]  ch3DcFilterCtrl_q,
  output reg         ch3SelPins_q,
  output reg         ch3SelShort_q,
  output reg         ch3SelPosTest_q,
  output reg         ch3SelNegTest_q
);

  // ----------------------------------------------------------------------
  // Access state machine codes
  // ----------------------------------------------------------------------
  localparam ACC_IDLE   = 1'b0;
  localparam ACC_ANSWER = 1'b1;

  reg         accState_q;
  reg         accState_d;

  // ----------------------------------------------------------------------
  // Address decode
  // ----------------------------------------------------------------------
  wire [7:0]  wordIdx;
  wire [7:0]  relIdx;
  wire        aligned;
  wire        inRange;
  wire        addrHit;
  wire [2:0]  regSel;

  // Index is the word address; the byte address is four times it
  assign wordIdx = paddr[9:2];
  assign relIdx  = wordIdx - `ACR_IDX_BASE;
  assign aligned = (paddr[1:0] == `ACR_ALIGN_OK);
  assign inRange = (wordIdx >= `ACR_IDX_BASE) && (wordIdx <= `ACR_IDX_CH3_CHANNEL_CONFIG);
  assign addrHit = aligned && inRange;
  assign regSel  = relIdx[2:0];

  // ----------------------------------------------------------------------
  // Transfer qualifiers
  // ----------------------------------------------------------------------
  wire        accessPhase;
  wire        commit;
  wire        commitWrite;

  // A transfer completes at the edge where pready is sampled high
  assign accessPhase = psel && penable;
  assign commit      = accessPhase && (accState_q == ACC_ANSWER);
  assign commitWrite = commit && pwrite && addrHit;

  // ----------------------------------------------------------------------
  // Register storage
  // ----------------------------------------------------------------------
  localparam [79:0] RESET_VEC = `ACR_RESET_VEC;
  localparam [79:0] WMASK_VEC = `ACR_WMASK_VEC;

  wire [15:0] regVal [0:4];
  wire [79:0] regFlat;
  wire [4:0]  regWr;

  // One masked register per map entry; reserved bits never take a write
  genvar g;
  generate
    for (g = 0; g < `ACR_NUM_REGS; g = g + 1) begin : gRegs
      assign regWr[g] = commitWrite && (regSel == g);
      acr_field_reg #(
        .RESET_VAL (RESET_VEC[g*16 +: 16]),
        .WR_MASK   (WMASK_VEC[g*16 +: 16])
      ) uReg (
        .clk       (clk),
        .reset_n   (reset_n),
        .wrEn      (regWr[g]),
        .wrData    (pwdata[15:0]),
        .byteEn    (pstrb[1:0]),
        .value_q   (regFlat[g*16 +: 16])
      );
      assign regVal[g] = regFlat[g*16 +: 16];
    end
  endgenerate

  // ----------------------------------------------------------------------
  // Named views of the stored fields
  // ----------------------------------------------------------------------
  wire [15:0] ch2OffsetUpperBits;
  wire [7:0]  ch2OffsetLowerBits;
  wire [15:0] ch2GainUpperBits;
  wire [7:0]  ch2GainLowerBits;
  wire [15:0] ch3Cfg;
  wire [9:0]  ch3PhaseField;
  wire        ch3DcOffField;
  wire [1:0]  ch3InputSelect;

  assign ch2OffsetUpperBits = regVal[`ACR_SEL_OFS_HI];
  assign ch2OffsetLowerBits = regVal[`ACR_SEL_OFS_LO][`ACR_LOWER_BYTE];
  assign ch2GainUpperBits   = regVal[`ACR_SEL_GAIN_HI];
  assign ch2GainLowerBits   = regVal[`ACR_SEL_GAIN_LO][`ACR_LOWER_BYTE];
  assign ch3Cfg             = regVal[`ACR_SEL_CH3_CHANNEL_CONFIG];
  assign ch3PhaseField      = ch3Cfg[`ACR_PHASE_FLD];
  assign ch3DcOffField      = ch3Cfg[`ACR_DCOFF_BIT];
  assign ch3InputSelect     = ch3Cfg[`ACR_MUX_FLD];

  // ----------------------------------------------------------------------
  // Read data
  // ----------------------------------------------------------------------
  reg  [15:0] readWord;
  wire [15:0] readMask;

  // Masking again on read keeps reserved bits zero even if storage slipped
  assign readMask = WMASK_VEC[regSel*16 +: 16];

  always @* begin
    readWord = `ACR_UPPER_ZERO;
    if (addrHit) begin
      readWord = regVal[regSel] & readMask;
    end
  end

  // ----------------------------------------------------------------------
  // APB access sequencing
  // ----------------------------------------------------------------------
  // One wait state: pready rises the cycle after the access phase opens
  always @* begin
    accState_d = accState_q;
    case (accState_q)
      ACC_IDLE: begin
        if (accessPhase) begin
          accState_d = ACC_ANSWER;
        end
      end
      ACC_ANSWER: begin
        accState_d = ACC_IDLE;
      end
      default: begin
        accState_d = ACC_IDLE;
      end
    endcase
  end

  always @(posedge clk) begin
    if (!reset_n) begin
      accState_q <= ACC_IDLE;
    end else begin
      accState_q <= accState_d;
    end
  end

  // ----------------------------------------------------------------------
  // APB answer registers
  // ----------------------------------------------------------------------
  // Unmapped or misaligned addresses answer with pslverr and zero data
  always @(posedge clk) begin
    if (!reset_n) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= `ACR_BUS_ZERO;
    end else if ((accState_q == ACC_IDLE) && accessPhase) begin
      pready  <= 1'b1;
      pslverr <= !addrHit;
      prdata  <= (pwrite || !addrHit) ? `ACR_BUS_ZERO : {`ACR_UPPER_ZERO, readWord};
    end else begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= `ACR_BUS_ZERO;
    end
  end

  // ----------------------------------------------------------------------
  // Channel 2 calibration words
  // ----------------------------------------------------------------------
  // Datapath sees the words one cycle after the write edge
  always @(posedge clk) begin
    if (!reset_n) begin
      ch2OffsetCorr_q <= `ACR_CORR_ZERO;
      ch2GainCorr_q   <= `ACR_GAIN_UNITY;
      ch2GainUnity_q  <= 1'b1;
    end else begin
      // Signed offset: upper word carries the sign bit
      ch2OffsetCorr_q <= {ch2OffsetUpperBits, ch2OffsetLowerBits};
      // Unsigned gain, 1.23 fraction: 800000h is unity, FFFFFFh just under two
      ch2GainCorr_q   <= {ch2GainUpperBits, ch2GainLowerBits};
      ch2GainUnity_q  <= ({ch2GainUpperBits, ch2GainLowerBits} == `ACR_GAIN_UNITY);
    end
  end

  // ----------------------------------------------------------------------
  // Channel 3 phase delay
  // ----------------------------------------------------------------------
  wire [9:0]  phaseNeg;

  // Two's complement negate; -512 gives magnitude 512, which still fits
  assign phaseNeg = ~ch3PhaseField + `ACR_PHASE_ONE;

  // Sign and magnitude saved for the delay line, counted in modulator cycles
  always @(posedge clk) begin
    if (!reset_n) begin
      ch3PhaseDelay_q     <= `ACR_PHASE_ZERO;
      ch3PhaseNegative_q  <= 1'b0;
      ch3PhaseMagnitude_q <= `ACR_PHASE_ZERO;
    end else begin
      ch3PhaseDelay_q     <= ch3PhaseField;
      ch3PhaseNegative_q  <= ch3Cfg[`ACR_PHASE_SIGN];
      if (ch3Cfg[`ACR_PHASE_SIGN]) begin
        ch3PhaseMagnitude_q <= phaseNeg;
      end else begin
        ch3PhaseMagnitude_q <= ch3PhaseField;
      end
    end
  end

  // ----------------------------------------------------------------------
  // Channel 3 DC-blocking filter control
  // ----------------------------------------------------------------------
  // Shared setting comes from logic on this clock, so no synchroniser
  always @(posedge clk) begin
    if (!reset_n) begin
      ch3DcFilterOff_q  <= 1'b0;
      ch3DcFilterCtrl_q <= `ACR_DC_BYPASS;
    end else begin
      ch3DcFilterOff_q <= ch3DcOffField;
      if (ch3DcOffField) begin
        ch3DcFilterCtrl_q <= `ACR_DC_BYPASS;
      end else begin
        ch3DcFilterCtrl_q <= globalDcFilterSetting;
      end
    end
  end

  // ----------------------------------------------------------------------
  // Channel 3 input selection
  // ----------------------------------------------------------------------
  reg         selPins;
  reg         selShort;
  reg         selPos;
  reg         selNeg;

  // One-hot decode so the analog switches never see two paths at once
  always @* begin
    selPins  = 1'b0;
    selShort = 1'b0;
    selPos   = 1'b0;
    selNeg   = 1'b0;
    case (ch3InputSelect)
      `ACR_MUX_PINS: begin
        selPins = 1'b1;
      end
      `ACR_MUX_SHORT: begin
        selShort = 1'b1;
      end
      `ACR_MUX_POS_TEST: begin
        selPos = 1'b1;
      end
      `ACR_MUX_NEG_TEST: begin
        selNeg = 1'b1;
      end
      default: begin
        selPins = 1'b1;
      end
    endcase
  end

  // Reset selects the external pin pair
  always @(posedge clk) begin
    if (!reset_n) begin
      ch3SelPins_q    <= 1'b1;
      ch3SelShort_q   <= 1'b0;
      ch3SelPosTest_q <= 1'b0;
      ch3SelNegTest_q <= 1'b0;
    end else begin
      ch3SelPins_q    <= selPins;
      ch3SelShort_q   <= selShort;
      ch3SelPosTest_q <= selPos;
      ch3SelNegTest_q <= selNeg;
    end
  end

endmodule

// ### tb/acr_cal_regs_checker.sv
// Concurrent checks on the ports of the calibration register slice
`timescale 1ns/1ps
module acr_cal_regs_checker (
  input logic        clk,
  input logic        reset_n,
  input logic        psel,
  input logic        penable,
  input logic        pwrite,
  input logic [9:0]  paddr,
  input logic [31:0] pwdata,
  input logic [3:0]  pstrb,
  input logic [31:0] prdata,
  input logic        pready,
  input logic [3:0]  globalDcFilterSetting,
  input logic [23:0] ch2OffsetCorr_q,
  input logic [23:0] ch2GainCorr_q,
  input logic [9:0]  ch3PhaseDelay_q,
  input logic        ch3DcFilterOff_q,
  input logic [3:0]  ch3DcFilterCtrl_q,
  input logic        ch3SelPins_q,
  input logic        ch3SelShort_q,
  input logic        ch3SelPosTest_q,
  input logic        ch3SelNegTest_q
);
  default clocking dc @(posedge clk); endclocking
  default disable iff (!reset_n);
  // ------------------------------------------------------------
  // Completed transfers, seen at the edge that samples pready
  // ------------------------------------------------------------
  sequence wrHit(logic [9:0] a);
    psel && penable && pready && pwrite && paddr == a && pstrb[1:0] == 2'h3;
  endsequence
  sequence rdHit(logic [9:0] a);
    psel && penable && pready && !pwrite && paddr == a;
  endsequence
  // Stored word reaches the outputs one edge after the store edge
  ofs_high_a: assert property (wrHit(10'h050) |=> ##1
    ch2OffsetCorr_q[23:8] == $past(pwdata[15:0], 2)) else $error("offset high lost");
  ofs_low_a: assert property (wrHit(10'h054) |=> ##1
    ch2OffsetCorr_q[7:0] == $past(pwdata[15:8], 2)) else $error("offset low lost");
  gain_high_a: assert property (wrHit(10'h058) |=> ##1
    ch2GainCorr_q[23:8] == $past(pwdata[15:0], 2)) else $error("gain high lost");
  gain_low_a: assert property (wrHit(10'h05C) |=> ##1
    ch2GainCorr_q[7:0] == $past(pwdata[15:8], 2)) else $error("gain low lost");
  phase_field_a: assert property (wrHit(10'h060) |=> ##1
    ch3PhaseDelay_q == $past(pwdata[15:6], 2)) else $error("phase delay lost");
  input_select_a: assert property (wrHit(10'h060) |=> ##1
    {ch3SelNegTest_q, ch3SelPosTest_q, ch3SelShort_q, ch3SelPins_q}
      == 4'h1 << $past(pwdata[1:0], 2)) else $error("input select decode wrong");
  // Low bytes and reserved bits read as zero
  low_byte_a: assert property ((rdHit(10'h054) or rdHit(10'h05C)) |->
    prdata[7:0] == 8'h00) else $error("low byte not zero");
  cfg_reserved_a: assert property (rdHit(10'h060) |-> prdata[5:3] == 3'h0)
    else $error("reserved bits not zero");
  // Filter control passes the shared field unless this channel opts out
  dc_filter_a: assert property ($past(reset_n) |->
    ch3DcFilterCtrl_q == (ch3DcFilterOff_q ? 4'h0 : $past(globalDcFilterSetting)))
    else $error("filter control wrong");
  reset_value_a: assert property ($rose(reset_n) |->
    ch2GainCorr_q == 24'h80_0000 && ch2OffsetCorr_q == 24'h00_0000)
    else $error("reset values wrong");
endmodule

bind acr_cal_regs acr_cal_regs_checker acr_cal_regs_checker_i (
  .clk, .reset_n, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .prdata, .pready,
  .globalDcFilterSetting, .ch2OffsetCorr_q, .ch2GainCorr_q, .ch3PhaseDelay_q,
  .ch3DcFilterOff_q, .ch3DcFilterCtrl_q, .ch3SelPins_q, .ch3SelShort_q,
  .ch3SelPosTest_q, .ch3SelNegTest_q);

// ### tb/acr_apb_host.sv
// Host model that issues APB register transfers
`timescale 1ns/1ps
module acr_apb_host (
  input  wire         clk,
  input  wire         pready,
  input  wire         pslverr,
  input  wire  [31:0] prdata,
  output logic        psel,
  output logic        penable,
  output logic        pwrite,
  output logic [9:0]  paddr,
  output logic [31:0] pwdata,
  output logic [3:0]  pstrb
);
  // Idle bus at time zero
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 10'h3FF;
    pwdata = 32'h0;
    pstrb = 4'h0;
  end
  // Upper data half is junk on purpose; the slave must ignore it
  task automatic xfer(input logic w, input logic [9:0] a, input logic [15:0] d,
                      input logic [3:0] s, output logic [31:0] rd, output logic err);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {~d, d};
    pstrb <= s;
    @(posedge clk);
    penable <= 1'b1;
    // Answer is taken at the rising edge that samples pready high, then released
    @(posedge clk);
    while (pready !== 1'b1) @(posedge clk);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    paddr <= ~paddr;
    pwdata <= ~pwdata;
    pstrb <= ~pstrb;
  endtask
endmodule

// ### tb/testbench.sv
// Self-checking bench for the calibration register slice
`timescale 1ns/1ps
module testbench;
  logic        clk = 1'b0;
  logic        reset_n = 1'b0;
  logic [3:0]  globalDcFilterSetting = 4'h9;
  wire         psel, penable, pwrite, pready, pslverr;
  wire  [9:0]  paddr;
  wire  [31:0] pwdata, prdata;
  wire  [3:0]  pstrb, ch3DcFilterCtrl_q;
  wire  [23:0] ch2OffsetCorr_q, ch2GainCorr_q;
  wire  [9:0]  ch3PhaseDelay_q, ch3PhaseMagnitude_q;
  wire         ch2GainUnity_q, ch3DcFilterOff_q, ch3PhaseNegative_q;
  wire         ch3SelPins_q, ch3SelShort_q, ch3SelPosTest_q, ch3SelNegTest_q;
  int          n_fail = 0;
  int          checks = 0;
  int          cyc = 0;
  logic [31:0] rd;
  logic        err;
  logic [9:0]  phaseMag;
  logic [41:0] rows [0:7];

  always #5 clk = ~clk;

  acr_apb_host acr_apb_host_i (.clk, .pready, .pslverr, .prdata, .psel, .penable,
    .pwrite, .paddr, .pwdata, .pstrb);
  acr_cal_regs acr_cal_regs_i (.clk, .reset_n, .psel, .penable, .pwrite, .paddr,
    .pwdata, .pstrb, .prdata, .pready, .pslverr, .globalDcFilterSetting,
    .ch2OffsetCorr_q, .ch2GainCorr_q, .ch2GainUnity_q, .ch3PhaseDelay_q,
    .ch3PhaseNegative_q, .ch3PhaseMagnitude_q, .ch3DcFilterOff_q,
    .ch3DcFilterCtrl_q, .ch3SelPins_q, .ch3SelShort_q, .ch3SelPosTest_q,
    .ch3SelNegTest_q);

  // ------------------------------------------------------------
  // Compare, report and close
  // ------------------------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      n_fail++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic tally_and_finish;
    $display("checks %0d n_fail %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic rw(input logic w, input logic [9:0] a, input logic [15:0] d,
                    input logic [3:0] s);
    acr_apb_host_i.xfer(w, a, d, s, rd, err);
  endtask
  // Hang guard, far above the roughly 130 cycles the run needs
  always @(posedge clk) begin
    cyc++;
    if (cyc == 3000) begin
      n_fail++;
      tally_and_finish;
    end
  end

  initial begin
    // Address, write data, expected read-back
    rows = '{{10'h050, 16'hA5C3, 16'hA5C3}, {10'h054, 16'h7EFF, 16'h7E00},
             {10'h058, 16'hFFFF, 16'hFFFF}, {10'h05C, 16'h12FF, 16'h1200},
             {10'h060, 16'hFFFF, 16'hFFC7}, {10'h060, 16'h8001, 16'h8001},
             {10'h060, 16'h0002, 16'h0002}, {10'h060, 16'h0007, 16'h0007}};
    repeat (5) @(posedge clk);
    reset_n <= 1'b1;
    for (int i = 0; i < 5; i++) begin
      rw(1'b0, 10'h050 + 10'(4 * i), 16'h0, 4'h0);
      chk(rd, i == 2 ? 32'h8000 : 32'h0);
    end
    chk({7'h0, ch2GainUnity_q, ch2GainCorr_q}, 32'h0180_0000);
    foreach (rows[i]) begin
      rw(1'b1, rows[i][41:32], rows[i][31:16], 4'hF);
      rw(1'b0, rows[i][41:32], 16'h0, 4'h0);
      chk(rd, {16'h0, rows[i][15:0]});
      if (rows[i][41:32] == 10'h060) begin
        chk({ch3PhaseDelay_q, ch3DcFilterOff_q, ch3SelNegTest_q, ch3SelPosTest_q,
             ch3SelShort_q, ch3SelPins_q},
            {rows[i][31:22], rows[i][18], 4'h1 << rows[i][17:16]});
        // Sign and size of the signed delay
        phaseMag = rows[i][31] ? 10'h000 - rows[i][31:22] : rows[i][31:22];
        chk({ch3PhaseNegative_q, ch3PhaseMagnitude_q}, {rows[i][31], phaseMag});
      end
    end
    chk({8'h0, ch2OffsetCorr_q}, 32'hA5C37E);
    chk({7'h0, ch2GainUnity_q, ch2GainCorr_q}, 32'h00FF_FF12);
    chk(ch3DcFilterCtrl_q, 32'h0);
    // Filter back under the shared field, which then changes
    rw(1'b1, 10'h060, 16'h0000, 4'hF);
    repeat (2) @(negedge clk);
    chk({ch3SelPins_q, ch3DcFilterCtrl_q}, 32'h19);
    @(posedge clk) globalDcFilterSetting <= 4'h5;
    repeat (2) @(negedge clk);
    chk(ch3DcFilterCtrl_q, 32'h5);
    // Only the strobed byte lane changes
    rw(1'b1, 10'h050, 16'h0000, 4'h1);
    rw(1'b0, 10'h050, 16'h0, 4'h0);
    chk(rd, 32'hA500);
    // Unmapped and misaligned addresses answer with an error
    rw(1'b0, 10'h000, 16'h0, 4'h0);
    chk({rd[30:0], err}, 32'h1);
    rw(1'b0, 10'h051, 16'h0, 4'h0);
    chk({rd[30:0], err}, 32'h1);
    // Second reset in mid-run restores the defaults
    @(posedge clk) reset_n <= 1'b0;
    repeat (2) @(posedge clk);
    reset_n <= 1'b1;
    rw(1'b0, 10'h058, 16'h0, 4'h0);
    chk(rd, 32'h8000);
    rw(1'b0, 10'h050, 16'h0, 4'h0);
    chk(rd, 32'h0);
    tally_and_finish;
  end
endmodule
